/* File: adc_ctrl_pkg.sv */
// package: constants shared by the sample output control block
package adc_ctrl_pkg;
  localparam int          SAMPLE_WIDTH      = 14;
  localparam int          MAX_RATE_MSPS     = 80;
  localparam logic [13:0] CODE_UNDER_RANGE  = 14'h0000;
  localparam logic [13:0] CODE_OVER_RANGE   = 14'h3fff;
  localparam logic [13:0] SAMPLE_WORD_RESET = 14'h0000;
  localparam logic [1:0]  SELECT_GROUND     = 2'h0;
  localparam logic [1:0]  SELECT_ONE_THIRD  = 2'h1;
  localparam logic [1:0]  SELECT_TWO_THIRDS = 2'h2;
  localparam logic [1:0]  SELECT_SUPPLY     = 2'h3;
  localparam int          REF_CLK_MHZ       = 200;
  localparam int          MIN_SAMPLE_NS     = 1000 / MAX_RATE_MSPS;
  localparam int          MIN_SAMPLE_CYCLES = (MIN_SAMPLE_NS * REF_CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_PARKED = 2'b01
  } power_state_t;
endpackage : adc_ctrl_pkg

/* File: pin_sync.sv */
// module: two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule : pin_sync

/* File: sample_output_ctrl.sv */
// module: sample capture, format select, power-down and output strobe
`timescale 1ns/1ps
module sample_output_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int WIDTH = SAMPLE_WIDTH
) (
  input  wire logic             ref_clk_in,
  input  wire logic             reset_in,
  input  wire logic             sample_clk_in,
  input  wire logic [WIDTH-1:0] analog_code_in,
  input  wire logic             under_range_in,
  input  wire logic             over_range_in,
  input  wire logic [1:0]       format_stabilizer_select_in,
  input  wire logic             power_down_input_in,
  output logic [WIDTH-1:0]      sample_word_bits_out,
  output logic                  output_valid_strobe_out,
  output logic                  duty_cycle_stabilizer_out,
  output logic                  twos_complement_out,
  output logic                  powered_down_out
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = 2 * WIDTH + 6;
  logic [SYNC_W-1:0] pins_sync;
  logic [WIDTH-1:0]  code_s;
  logic              clk_s;
  logic              under_s;
  logic              over_s;
  logic [1:0]        sel_s;
  logic              pd_s;

  // the code passes the same two-flop synchroniser as the clock pin, so the
  // source must hold it steady across the sampling edge
  pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .async_in   ({{WIDTH{1'b0}}, analog_code_in, sample_clk_in, under_range_in,
                  over_range_in, format_stabilizer_select_in, power_down_input_in}),
    .sync_out   (pins_sync)
  );
  assign {code_s, clk_s, under_s, over_s, sel_s, pd_s} = pins_sync[SYNC_W-WIDTH-1:0];

  // ----------------------------------------------------------------
  // decode of the four-level select
  // ----------------------------------------------------------------
  function automatic logic sel_twos(input logic [1:0] sel);
    return (sel == SELECT_SUPPLY) || (sel == SELECT_TWO_THIRDS);
  endfunction : sel_twos

  function automatic logic sel_dcs(input logic [1:0] sel);
    return (sel == SELECT_ONE_THIRD) || (sel == SELECT_TWO_THIRDS);
  endfunction : sel_dcs

  // ----------------------------------------------------------------
  // datapath and state
  // ----------------------------------------------------------------
  power_state_t     state_reg, state_next;
  logic             clk_prev_reg, clk_prev_next;
  logic [WIDTH-1:0] word_reg, word_next;
  logic             strobe_reg, strobe_next;
  logic             dcs_reg, dcs_next;
  logic             twos_reg, twos_next;
  logic             pd_reg, pd_next;
  logic [WIDTH-1:0] raw_code;
  logic             rise;
  logic             fall;

  assign rise = clk_s & ~clk_prev_reg;
  assign fall = ~clk_s & clk_prev_reg;

  always_comb begin
    clk_prev_next = clk_s;
    state_next    = pd_s ? ST_PARKED : ST_ACTIVE;
    twos_next     = sel_twos(sel_s);
    dcs_next      = sel_dcs(sel_s);
    pd_next       = pd_s;
    word_next     = word_reg;
    strobe_next   = strobe_reg;
    if (under_s) begin
      raw_code = CODE_UNDER_RANGE;
    end else if (over_s) begin
      raw_code = CODE_OVER_RANGE;
    end else begin
      raw_code = code_s;
    end
    // parked: strobe and word freeze, saving output switching
    if (state_reg == ST_ACTIVE) begin
      if (rise) begin
        // bit order kept: result lsb stays on bit 0
        word_next   = twos_reg ? {~raw_code[WIDTH-1], raw_code[WIDTH-2:0]} : raw_code;
        strobe_next = 1'b0;
      end else if (fall) begin
        strobe_next = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_reg    <= ST_ACTIVE;
      clk_prev_reg <= 1'b0;
      word_reg     <= SAMPLE_WORD_RESET;
      strobe_reg   <= 1'b0;
      dcs_reg      <= 1'b0;
      twos_reg     <= 1'b0;
      pd_reg       <= 1'b0;
    end else begin
      state_reg    <= state_next;
      clk_prev_reg <= clk_prev_next;
      word_reg     <= word_next;
      strobe_reg   <= strobe_next;
      dcs_reg      <= dcs_next;
      twos_reg     <= twos_next;
      pd_reg       <= pd_next;
    end
  end

  assign sample_word_bits_out      = word_reg;
  assign output_valid_strobe_out   = strobe_reg;
  assign duty_cycle_stabilizer_out = dcs_reg;
  assign twos_complement_out       = twos_reg;
  assign powered_down_out          = pd_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_word_on_strobe_fall;
    @(posedge ref_clk_in) disable iff (reset_in)
      $changed(word_reg) |-> $fell(strobe_reg);
  endproperty
  a_word_on_strobe_fall: assert property (p_word_on_strobe_fall) else $error("word changed off strobe fall");

  property p_sample_on_rise;
    @(posedge ref_clk_in) disable iff (reset_in)
      (rise && state_reg == ST_ACTIVE) |=> !strobe_reg;
  endproperty
  a_sample_on_rise: assert property (p_sample_on_rise) else $error("no capture on rise");

  property p_supply_mode;
    @(posedge ref_clk_in) disable iff (reset_in)
      (sel_s == SELECT_SUPPLY) |=> (twos_reg && !dcs_reg);
  endproperty
  a_supply_mode: assert property (p_supply_mode) else $error("supply mode wrong");

  property p_ground_mode;
    @(posedge ref_clk_in) disable iff (reset_in)
      (sel_s == SELECT_GROUND) |=> (!twos_reg && !dcs_reg);
  endproperty
  a_ground_mode: assert property (p_ground_mode) else $error("ground mode wrong");

  property p_two_thirds_mode;
    @(posedge ref_clk_in) disable iff (reset_in)
      (sel_s == SELECT_TWO_THIRDS) |=> (twos_reg && dcs_reg);
  endproperty
  a_two_thirds_mode: assert property (p_two_thirds_mode) else $error("two thirds mode wrong");

  property p_one_third_mode;
    @(posedge ref_clk_in) disable iff (reset_in)
      (sel_s == SELECT_ONE_THIRD) |=> (!twos_reg && dcs_reg);
  endproperty
  a_one_third_mode: assert property (p_one_third_mode) else $error("one third mode wrong");

  property p_parked_frozen;
    @(posedge ref_clk_in) disable iff (reset_in)
      (pd_s ##1 pd_s) |=> $stable(word_reg) && $stable(strobe_reg);
  endproperty
  a_parked_frozen: assert property (p_parked_frozen) else $error("output moved in power-down");

  property p_normal_when_low;
    @(posedge ref_clk_in) disable iff (reset_in)
      !pd_s |=> (state_reg == ST_ACTIVE) && !powered_down_out;
  endproperty
  a_normal_when_low: assert property (p_normal_when_low) else $error("not active with power-down low");

  property p_over_range;
    @(posedge ref_clk_in) disable iff (reset_in)
      (rise && over_s && !under_s && state_reg == ST_ACTIVE)
      |=> word_reg == (twos_reg ? {1'b0, CODE_OVER_RANGE[12:0]} : CODE_OVER_RANGE);
  endproperty
  a_over_range: assert property (p_over_range) else $error("over range code wrong");

  property p_under_range;
    @(posedge ref_clk_in) disable iff (reset_in)
      (rise && under_s && state_reg == ST_ACTIVE && !twos_reg) |=> word_reg == CODE_UNDER_RANGE;
  endproperty
  a_under_range: assert property (p_under_range) else $error("under range code wrong");

  c_capture:   cover property (@(posedge ref_clk_in) disable iff (reset_in) rise && state_reg == ST_ACTIVE);
  c_twos_word: cover property (@(posedge ref_clk_in) disable iff (reset_in) twos_reg && $fell(strobe_reg));
  c_park:      cover property (@(posedge ref_clk_in) disable iff (reset_in) $rose(powered_down_out));
  c_dcs_on:    cover property (@(posedge ref_clk_in) disable iff (reset_in) $rose(dcs_reg));
endmodule : sample_output_ctrl

/* File: sample_receiver.sv */
// receiving logic model: captures each sample word on the strobe rise
`timescale 1ns/1ps
module sample_receiver (
  input  wire logic [13:0] word_in,
  input  wire logic        strobe_in,
  output logic [13:0]      held_word_out,
  output int               capture_count_out
);
  int count = 0;
  // the word moves on the strobe fall, so the rise is the quiet point
  always @(posedge strobe_in) begin
    held_word_out <= word_in;
    count         <= count + 1;
  end
  assign capture_count_out = count;
endmodule : sample_receiver

/* File: pipelined_adc_output_control_test.sv */
// self-checking bench for the sample output control block
`timescale 1ns/1ps
module pipelined_adc_output_control_test;
  import adc_ctrl_pkg::*;
  logic        ref_clk    = 1'b0;
  logic        reset      = 1'b1;
  logic        sclk       = 1'b0;
  logic [13:0] code       = 14'h0000;
  logic        under      = 1'b0;
  logic        over       = 1'b0;
  logic [1:0]  sel        = SELECT_GROUND;
  logic        power_down = 1'b0;
  logic [13:0] word;
  logic [13:0] held;
  logic        strobe;
  logic        stab;
  logic        twos;
  logic        parked;
  int          captures;
  int          errors     = 0;
  int          n_checks   = 0;
  always #2.5 ref_clk = ~ref_clk;
  // sample clock runs free at 48 ns, offset so it never meets a ref edge
  initial begin
    #0.3;
    forever #24 sclk = ~sclk;
  end
  sample_output_ctrl sample_output_ctrl_inst (
    .ref_clk_in(ref_clk), .reset_in(reset), .sample_clk_in(sclk), .analog_code_in(code),
    .under_range_in(under), .over_range_in(over), .format_stabilizer_select_in(sel),
    .power_down_input_in(power_down), .sample_word_bits_out(word), .output_valid_strobe_out(strobe),
    .duty_cycle_stabilizer_out(stab), .twos_complement_out(twos), .powered_down_out(parked));
  sample_receiver sample_receiver_inst (
    .word_in(word), .strobe_in(strobe), .held_word_out(held), .capture_count_out(captures));
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_strobe(input logic v);
    int i;
    @(negedge ref_clk);
    for (i = 0; i < 60 && strobe !== v; i++) @(negedge ref_clk);
    if (strobe !== v) begin
      errors++;
      $display("wrong value at %0t: strobe got %h expected %h", $time, strobe, v);
      final_report();
    end
  endtask : wait_strobe
  // inputs change just after a capture, so they are settled by the next rise
  task automatic take(input logic [13:0] c, input logic [1:0] s, input logic u, input logic o);
    logic [13:0] exp;
    logic        tc;
    tc  = (s == SELECT_SUPPLY) || (s == SELECT_TWO_THIRDS);
    exp = u ? CODE_UNDER_RANGE : (o ? CODE_OVER_RANGE : c);
    exp[13] = exp[13] ^ tc;
    wait_strobe(1'b0);
    code = c;
    sel = s;
    under = u;
    over = o;
    wait_strobe(1'b1);
    wait_strobe(1'b0);
    check({2'h0, word}, {2'h0, exp});
    check({15'h0, twos}, {15'h0, tc});
    check({15'h0, stab}, {15'h0, (s == SELECT_ONE_THIRD) || (s == SELECT_TWO_THIRDS)});
    wait_strobe(1'b1);
    check({2'h0, held}, {2'h0, exp});
  endtask : take
  task automatic test_formats();
    logic [13:0] codes [4] = '{14'h0001, 14'h2abc, 14'h3ffe, 14'h1555};
    for (int i = 0; i < 4; i++) take(codes[i], 2'(i), 1'b0, 1'b0);
    take(14'h2000, SELECT_SUPPLY, 1'b0, 1'b0);
    $display("test formats done");
  endtask : test_formats
  task automatic test_range();
    take(14'h1234, SELECT_GROUND, 1'b1, 1'b0);
    take(14'h1234, SELECT_GROUND, 1'b0, 1'b1);
    take(14'h0234, SELECT_GROUND, 1'b1, 1'b1);
    take(14'h1234, SELECT_SUPPLY, 1'b0, 1'b1);
    $display("test range done");
  endtask : test_range
  task automatic test_power_down();
    int          n;
    logic [13:0] w;
    take(14'h0f0f, SELECT_GROUND, 1'b0, 1'b0);
    power_down = 1'b1;
    repeat (8) @(negedge ref_clk);
    check({15'h0, parked}, 16'h0001);
    n = captures;
    w = word;
    code = 14'h3333;
    repeat (40) @(negedge ref_clk);
    check(captures[15:0], n[15:0]);
    check({2'h0, word}, {2'h0, w});
    power_down = 1'b0;
    repeat (8) @(negedge ref_clk);
    check({15'h0, parked}, 16'h0000);
    take(14'h0abc, SELECT_GROUND, 1'b0, 1'b0);
    $display("test power down done");
  endtask : test_power_down
  initial begin
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    repeat (3) @(negedge ref_clk);
    test_formats();
    test_range();
    test_power_down();
    final_report();
  end
endmodule : pipelined_adc_output_control_test
